// ### rtl/adc_output_formatter_regs.vh
// Purpose: register offsets, fields and reset values of the output formatter
// Assumes: 7-bit register address, 8-bit data
// Notes:   field positions inside registers are local layout choices
`ifndef ADC_OUTPUT_FORMATTER_REGS_VH
`define ADC_OUTPUT_FORMATTER_REGS_VH

`define ADDR_OUTPUT_RANDOMIZER_WORD_CONTROL 7'h07
`define ADDR_OUTPUT_FORMAT_MODE_CONTROL     7'h62
`define ADDR_LVDS_DRIVER_CONTROL            7'h63
`define ADDR_LVDS_DATA_PAIR_POLARITY        7'h65
`define ADDR_OVERRANGE_MARKER_CONTROL       7'h68

// output_format_mode_control fields
`define FMT_TWOS_BIT      0
`define MODE_LSB          1
`define DDR_MSB_FIRST_BIT 3
`define RES_LSB           4
// output_randomizer_word_control fields
`define RANDOMIZE_BIT     0
`define IQ_MODE_BIT       1
`define CHAN_CNT_LSB      4
// overrange_marker_control fields
`define MARKER_INV_BIT    0
`define EXTRA_INV_BIT     1

// Output modes
`define MODE_OFF          2'h0
`define MODE_CMOS         2'h1
`define MODE_DDR          2'h2
`define MODE_SERIAL       2'h3
// Resolution codes
`define RES_16            2'h0
`define RES_14            2'h1
`define RES_18            2'h2

// Reset values
`define RST_FORMAT_MODE   8'h03
`define RST_RANDOMIZER    8'h00
`define RST_DRIVER        8'h01
`define RST_POLARITY      8'h00
`define RST_MARKER        8'h00

// Drive-current codes
`define CUR_1P8MA         3'h0
`define CUR_3P5MA         3'h1
`define CUR_5P4MA         3'h2
`define CUR_7P2MA         3'h3

`define POSTPROC_DELAY    4
`endif

// ### rtl/sample_fifo.v
// Purpose: small synchronous FIFO in the sample path
// Assumes: single clock, depth a power of two
// Notes:   full and empty derive from a pointer with an extra wrap bit
`timescale 1ns/1ps
module sample_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             i_clk_sys,
  input  wire             i_reset,
  input  wire             i_ce,
  // Fill side
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  // Drain side
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr_ff;
  reg [AW:0]      rd_ptr_ff;
  wire            full;
  wire            empty;
  wire            do_wr;
  wire            do_rd;

  // Status from pointers
  assign full        = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                       (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign empty       = (wr_ptr_ff == rd_ptr_ff);
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem[rd_ptr_ff[AW-1:0]];
  assign do_wr       = i_ce && i_in_valid && !full;
  assign do_rd       = i_ce && i_out_ready && !empty;

  // Storage write
  always @(posedge i_clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr_ff[AW-1:0]] <= i_in_data;
    end
  end

  // Pointers
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr_ff <= {(AW+1){1'b0}};
      rd_ptr_ff <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end
endmodule // sample_fifo

// ### rtl/adc_output_formatter.v
// Purpose: output formatting stage of a multi-channel 16-bit converter
// Assumes: samples arrive as two's complement codes with overrange and
//          channel index; register port is a simple address/write strobe
// Notes:   the output strobe clock toggles on i_clk_sys; each DDR half is
//          one system cycle
`timescale 1ns/1ps
`include "adc_output_formatter_regs.vh"
module adc_output_formatter #(
  parameter DW       = 16,
  parameter FIFO_DEP = 8,
  parameter FIFO_AW  = 3
) (
  // Clock and reset
  input  wire          i_clk_sys,
  input  wire          i_reset,
  input  wire          i_ce,
  // Register port
  input  wire [6:0]    i_reg_addr,
  input  wire          i_reg_wr,
  input  wire [7:0]    i_reg_wdata,
  output reg  [7:0]    o_reg_rdata,
  // Sample input from converter core
  input  wire          i_smp_valid,
  output wire          o_smp_ready,
  input  wire [DW-1:0] i_smp_code,
  input  wire          i_smp_over_pos,
  input  wire          i_smp_over_neg,
  input  wire          i_smp_at_pos,
  input  wire          i_smp_at_neg,
  input  wire [1:0]    i_smp_extra,
  input  wire [2:0]    i_smp_chan,
  input  wire          i_post_processing,
  // Data outputs
  output reg  [DW-1:0] o_data_out,
  output reg  [1:0]    o_extra_bits,
  output reg           o_overrange_flag,
  output reg           o_word_marker,
  output reg           o_output_strobe_clock,
  output wire          o_out_enable,
  output wire [2:0]    o_driver_current_select
);
  localparam ST_IDLE = 2'h0;
  localparam ST_LOAD = 2'h1;
  localparam ST_SHIFT = 2'h2;

  reg  [7:0]  fmt_mode_ff;
  reg  [7:0]  rand_ff;
  reg  [7:0]  drv_ff;
  reg  [7:0]  pol_ff;
  reg  [7:0]  mark_ff;
  reg  [1:0]  state_ff;
  reg  [3:0]  bit_cnt_ff;
  reg  [DW-1:0] shreg_ff;
  reg  [DW-1:0] lane_ff [0:7];
  reg  [DW-1:0] dly_ff [0:`POSTPROC_DELAY-1];
  reg         ovr_hold_ff;
  reg         mrk_hold_ff;
  reg  [1:0]  ext_hold_ff;
  reg         any_ovr_ff;
  wire [1:0]  mode;
  wire [1:0]  res;
  wire        single_ch;
  wire        fifo_vld;
  reg         fifo_rdy;
  wire [DW+5:0] fifo_dout;
  wire [DW-1:0] f_code;
  wire        f_ovr;
  wire [2:0]  f_chan;
  wire [1:0]  f_ext;
  reg  [DW-1:0] sat_code;
  reg  [DW-1:0] fmt_code;
  wire [DW-1:0] data_sel;
  integer     k;

  assign mode  = fmt_mode_ff[`MODE_LSB+1:`MODE_LSB];
  assign res   = fmt_mode_ff[`RES_LSB+1:`RES_LSB];
  assign single_ch = (rand_ff[`CHAN_CNT_LSB+2:`CHAN_CNT_LSB] == 3'h0);
  assign o_out_enable = (mode != `MODE_OFF);
  assign o_driver_current_select = drv_ff[2:0];

  // Pair inversion applied to an LVDS data byte
  function [7:0] pair_inv;
    input [7:0] v;
    input [7:0] inv;
    begin
      pair_inv = v ^ inv;
    end
  endfunction

  // Registers; mode, format, resolution, randomizer, polarity and marker fields all steer the outputs
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      fmt_mode_ff <= `RST_FORMAT_MODE;
      rand_ff     <= `RST_RANDOMIZER;
      drv_ff      <= `RST_DRIVER;
      pol_ff      <= `RST_POLARITY;
      mark_ff     <= `RST_MARKER;
    end else if (i_ce && i_reg_wr) begin
      case (i_reg_addr)
        `ADDR_OUTPUT_RANDOMIZER_WORD_CONTROL: rand_ff <= i_reg_wdata;
        `ADDR_OUTPUT_FORMAT_MODE_CONTROL:     fmt_mode_ff <= i_reg_wdata;
        `ADDR_LVDS_DRIVER_CONTROL:            drv_ff <= {5'h00, i_reg_wdata[2:0]};
        `ADDR_LVDS_DATA_PAIR_POLARITY:        pol_ff <= i_reg_wdata;
        `ADDR_OVERRANGE_MARKER_CONTROL:       mark_ff <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    case (i_reg_addr)
      `ADDR_OUTPUT_RANDOMIZER_WORD_CONTROL: o_reg_rdata = rand_ff;
      `ADDR_OUTPUT_FORMAT_MODE_CONTROL:     o_reg_rdata = fmt_mode_ff;
      `ADDR_LVDS_DRIVER_CONTROL:            o_reg_rdata = drv_ff;
      `ADDR_LVDS_DATA_PAIR_POLARITY:        o_reg_rdata = pol_ff;
      `ADDR_OVERRANGE_MARKER_CONTROL:       o_reg_rdata = mark_ff;
      default:                              o_reg_rdata = 8'h00;
    endcase
  end

  // Saturate and format before buffering
  always @* begin
    sat_code = i_smp_code;
    if (i_smp_over_pos || i_smp_at_pos) begin
      sat_code = {1'b0, {(DW-1){1'b1}}};
    end else if (i_smp_over_neg || i_smp_at_neg) begin
      sat_code = {1'b1, {(DW-1){1'b0}}};
    end
    // Offset binary is the sign bit flipped, so zero becomes 0x8000
    fmt_code = sat_code;
    if (!fmt_mode_ff[`FMT_TWOS_BIT]) begin
      fmt_code = {~sat_code[DW-1], sat_code[DW-2:0]};
    end
  end

  sample_fifo #(
    .WIDTH (DW + 6),
    .DEPTH (FIFO_DEP),
    .AW    (FIFO_AW)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_reset     (i_reset),
    .i_ce        (i_ce),
    .i_in_valid  (i_smp_valid),
    .o_in_ready  (o_smp_ready),
    // Flag only strictly beyond full scale
    .i_in_data   ({i_smp_extra, i_smp_chan, i_smp_over_pos | i_smp_over_neg, fmt_code}),
    .o_out_valid (fifo_vld),
    .i_out_ready (fifo_rdy),
    .o_out_data  (fifo_dout)
  );

  assign f_code = fifo_dout[DW-1:0];
  assign f_ovr  = fifo_dout[DW];
  assign f_chan = fifo_dout[DW+3:DW+1];
  assign f_ext  = fifo_dout[DW+5:DW+4];

  // Post-processing delays data while the flag takes the direct path
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      for (k = 0; k < `POSTPROC_DELAY; k = k + 1) begin
        dly_ff[k] <= {DW{1'b0}};
      end
    end else if (i_ce && fifo_rdy && fifo_vld) begin
      dly_ff[0] <= f_code;
      for (k = 1; k < `POSTPROC_DELAY; k = k + 1) begin
        dly_ff[k] <= dly_ff[k-1];
      end
    end
  end
  assign data_sel = i_post_processing ? dly_ff[`POSTPROC_DELAY-1] : f_code;

  // Drain pace: CMOS one word per strobe period, DDR one word per period,
  // serialized waits for eight channels then shifts sixteen halves.
  // Drain while the strobe is high so both DDR halves come from one word
  always @* begin
    fifo_rdy = 1'b0;
    case (state_ff)
      ST_IDLE:  fifo_rdy = (mode != `MODE_OFF) && o_output_strobe_clock;
      ST_LOAD:  fifo_rdy = 1'b1;
      ST_SHIFT: fifo_rdy = 1'b0;
      default:  fifo_rdy = 1'b0;
    endcase
    if (mode == `MODE_SERIAL && state_ff == ST_IDLE) begin
      fifo_rdy = 1'b1;
    end
  end

  // Output sequencer
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state_ff              <= ST_IDLE;
      bit_cnt_ff            <= 4'h0;
      shreg_ff              <= {DW{1'b0}};
      ovr_hold_ff           <= 1'b0;
      mrk_hold_ff           <= 1'b0;
      ext_hold_ff           <= 2'h0;
      any_ovr_ff            <= 1'b0;
      o_data_out            <= {DW{1'b0}};
      o_extra_bits          <= 2'h0;
      o_overrange_flag      <= 1'b0;
      o_word_marker         <= 1'b0;
      o_output_strobe_clock <= 1'b0;
      for (k = 0; k < 8; k = k + 1) begin
        lane_ff[k] <= {DW{1'b0}};
      end
    end else if (i_ce) begin
      if (mode == `MODE_OFF) begin
        // Data, extra, flag, marker and strobe outputs parked low while disabled
        state_ff              <= ST_IDLE;
        o_data_out            <= {DW{1'b0}};
        o_extra_bits          <= 2'h0;
        o_overrange_flag      <= 1'b0;
        o_word_marker         <= 1'b0;
        o_output_strobe_clock <= 1'b0;
      end else if (mode == `MODE_SERIAL) begin
        o_output_strobe_clock <= ~o_output_strobe_clock;
        case (state_ff)
          ST_IDLE: begin
            if (fifo_vld) begin
              // Gather one set; slot 7 lane holds first channel
              any_ovr_ff <= any_ovr_ff | f_ovr;
              for (k = 0; k < 8; k = k + 1) begin
                if (k == 7 - f_chan) begin
                  lane_ff[k] <= data_sel;
                end
              end
              if (f_chan == 3'h7) begin
                state_ff   <= ST_SHIFT;
                bit_cnt_ff <= 4'hf;
              end
            end
          end
          ST_SHIFT: begin
            // One bit per half period, MSB coincides with marker rise
            o_word_marker    <= (bit_cnt_ff == 4'hf);
            o_overrange_flag <= any_ovr_ff ^ mark_ff[`MARKER_INV_BIT];
            for (k = 0; k < 8; k = k + 1) begin
              o_data_out[k] <= lane_ff[k][bit_cnt_ff] ^ pol_ff[k];
            end
            bit_cnt_ff       <= bit_cnt_ff - 4'h1;
            if (bit_cnt_ff == 4'h0) begin
              state_ff   <= ST_IDLE;
              any_ovr_ff <= 1'b0;
            end
          end
          default: state_ff <= ST_IDLE;
        endcase
      end else begin
        o_output_strobe_clock <= ~o_output_strobe_clock;
        if (fifo_rdy && fifo_vld) begin
          // Marker with first channel; off in single channel unless I/Q
          mrk_hold_ff <= (f_chan == 3'h0) &&
                         (!single_ch || rand_ff[`IQ_MODE_BIT]);
          ovr_hold_ff <= f_ovr;
          ext_hold_ff <= f_ext;
          shreg_ff    <= rand_ff[`RANDOMIZE_BIT] ?
                         (data_sel ^ {{(DW-1){data_sel[0]}}, 1'b0}) : data_sel;
        end
        if (mode == `MODE_CMOS) begin
          // Full width on the rising edge of the strobe
          if (!o_output_strobe_clock) begin
            o_data_out       <= shreg_ff;
            o_extra_bits     <= ext_hold_ff;
            o_overrange_flag <= ovr_hold_ff;
            o_word_marker    <= mrk_hold_ff;
          end
        end else if (!o_output_strobe_clock) begin
          // Rising half: even bits or upper byte; marker on shared pair
          o_data_out[7:0] <= pair_inv(fmt_mode_ff[`DDR_MSB_FIRST_BIT] && res == `RES_16 ?
                             shreg_ff[15:8] :
                             {shreg_ff[14], shreg_ff[12], shreg_ff[10], shreg_ff[8],
                              shreg_ff[6], shreg_ff[4], shreg_ff[2], shreg_ff[0]},
                             pol_ff);
          o_word_marker   <= mrk_hold_ff ^ mark_ff[`MARKER_INV_BIT];
          o_extra_bits    <= {1'b0, ext_hold_ff[1] ^ mark_ff[`EXTRA_INV_BIT]};
        end else begin
          // Falling half: odd bits or lower byte; flag on shared pair
          o_data_out[7:0] <= pair_inv(fmt_mode_ff[`DDR_MSB_FIRST_BIT] && res == `RES_16 ?
                             shreg_ff[7:0] :
                             {shreg_ff[15], shreg_ff[13], shreg_ff[11], shreg_ff[9],
                              shreg_ff[7], shreg_ff[5], shreg_ff[3], shreg_ff[1]},
                             pol_ff);
          o_overrange_flag <= ovr_hold_ff ^ mark_ff[`MARKER_INV_BIT];
          o_extra_bits    <= {1'b0, ext_hold_ff[0] ^ mark_ff[`EXTRA_INV_BIT]};
        end
        if (mode == `MODE_DDR) begin
          // Unused pairs held low: pair 7 at 14-bit, extra pair unless 18-bit
          o_data_out[DW-1:8] <= {(DW-8){1'b0}};
          if (res == `RES_14) begin
            o_data_out[7] <= 1'b0;
          end
          if (res != `RES_18) begin
            o_extra_bits <= 2'h0;
          end
        end
      end
    end
  end
endmodule // adc_output_formatter

// ### verif/adc_output_formatter_assertions.sv
// Purpose: port-level checks of the output formatter
// Assumes: bench keeps i_ce high; mode is seen through the read port
// Notes:   mode-dependent checks fire only while address 0x62 is on the port
`timescale 1ns/1ps
module adc_output_formatter_assertions #(
  parameter DW = 16
) (
  // Clock and reset
  input wire          i_clk_sys,
  input wire          i_reset,
  // Register port
  input wire [6:0]    i_reg_addr,
  input wire          i_reg_wr,
  input wire [7:0]    o_reg_rdata,
  // Outputs
  input wire [DW-1:0] o_data_out,
  input wire          o_overrange_flag,
  input wire          o_word_marker,
  input wire          o_output_strobe_clock,
  input wire          o_out_enable,
  input wire [2:0]    o_driver_current_select
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // Decoded views of the read port
  wire       fmt_rd = (i_reg_addr == 7'h62);
  wire [1:0] mode   = o_reg_rdata[2:1];
  wire       mapped = (i_reg_addr == 7'h07) || fmt_rd || (i_reg_addr == 7'h63) ||
                      (i_reg_addr == 7'h65) || (i_reg_addr == 7'h68);

  chk_enable_follows_mode: assert property (fmt_rd |-> o_out_enable == (mode != 2'h0))
    else $error("enable does not follow mode field");
  chk_off_all_quiet: assert property (!o_out_enable [*2] |-> o_data_out == 16'h0000 &&
    !o_overrange_flag && !o_word_marker && !o_output_strobe_clock)
    else $error("outputs active while disabled");
  chk_current_from_field: assert property (i_reg_addr == 7'h63 |->
    o_driver_current_select == o_reg_rdata[2:0])
    else $error("drive current differs from field");
  chk_unmapped_reads_zero: assert property (!mapped |-> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_cmos_word_edge: assert property (fmt_rd && $stable(o_reg_rdata) && mode == 2'h1 &&
    $changed({o_data_out, o_overrange_flag, o_word_marker}) |-> $rose(o_output_strobe_clock))
    else $error("cmos word changed off the strobe rise");
  chk_strobe_needs_enable: assert property ($rose(o_output_strobe_clock) |->
    $past(o_out_enable))
    else $error("strobe rose while disabled");
  chk_ddr_both_edges: assert property (fmt_rd && $stable(o_reg_rdata) && mode == 2'h2 &&
    $changed(o_data_out) |-> $changed(o_output_strobe_clock))
    else $error("ddr data changed without a strobe edge");
  chk_cfg_write_only: assert property ($changed({o_out_enable, o_driver_current_select}) |->
    $past(i_reg_wr))
    else $error("configuration output moved without a write");

  // Main scenarios reached
  cov_cmos_word: cover property (fmt_rd && mode == 2'h1 && $rose(o_output_strobe_clock));
  cov_ddr_word: cover property (fmt_rd && mode == 2'h2 && $fell(o_output_strobe_clock));
  cov_disabled: cover property (!o_out_enable [*2]);
  cov_overrange: cover property ($rose(o_overrange_flag));
endmodule // adc_output_formatter_assertions

bind adc_output_formatter adc_output_formatter_assertions #(.DW(DW)) u_chk (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .o_reg_rdata(o_reg_rdata), .o_data_out(o_data_out), .o_overrange_flag(o_overrange_flag),
  .o_word_marker(o_word_marker), .o_output_strobe_clock(o_output_strobe_clock),
  .o_out_enable(o_out_enable), .o_driver_current_select(o_driver_current_select));

// ### verif/host_receiver_model.sv
// Purpose: host logic latching formatter pins on output strobe edges
// Assumes: strobe is slower than i_clk_sys so every edge is seen
// Notes:   captures both halves; the bench keeps the halves it wants
`timescale 1ns/1ps
module host_receiver_model (
  // Clock
  input wire        i_clk_sys,
  // Formatter pins
  input wire [15:0] i_data,
  input wire [1:0]  i_extra,
  input wire        i_ovr,
  input wire        i_marker,
  input wire        i_strobe
);
  logic [20:0] cap_q[$];
  logic        prev_ff = 1'b0;
  // Latch one word per strobe edge, tagged with the new strobe level
  always @(posedge i_clk_sys) begin
    if (i_strobe !== prev_ff) cap_q.push_back({i_strobe, i_marker, i_ovr, i_extra, i_data});
    prev_ff <= i_strobe;
  end
endmodule // host_receiver_model

// ### verif/adc_output_formatter_test.sv
// Purpose: self-checking bench of the output formatter
// Assumes: strobe runs free; captures of earlier words are flushed per send
// Notes:   DDR halves are compared on the low data byte
`timescale 1ns/1ps
`include "adc_output_formatter_regs.vh"
module adc_output_formatter_test;
  logic        i_clk_sys = 1'b0, i_reset = 1'b1, i_reg_wr = 1'b0, i_smp_valid = 1'b0;
  logic [6:0]  i_reg_addr = 7'h00;
  logic [7:0]  i_reg_wdata = 8'h00;
  logic [15:0] i_smp_code = 16'h0000;
  logic [3:0]  smp_flags = 4'h0;
  logic [1:0]  i_smp_extra = 2'h0;
  logic [2:0]  i_smp_chan = 3'h0;
  wire  [7:0]  o_reg_rdata;
  wire  [15:0] o_data_out;
  wire  [1:0]  o_extra_bits;
  wire  [2:0]  o_driver_current_select;
  wire         o_smp_ready, o_overrange_flag, o_word_marker, o_output_strobe_clock, o_out_enable;
  int          err_total = 0, checks = 0;
  logic [20:0] w;
  logic [15:0] lane_w[8];
  logic        i_post_processing = 1'b0;
  logic [7:0]  rst_v[6] = '{8'h00, 8'h03, 8'h01, 8'h00, 8'h00, 8'h00};
  logic [7:0]  wr_v[6] = '{8'h72, 8'h15, 8'h03, 8'ha5, 8'h03, 8'hff};
  logic [7:0]  rb_v[6] = '{8'h72, 8'h15, 8'h03, 8'ha5, 8'h03, 8'h00};
  logic [6:0]  adr_v[6] = '{7'h07, 7'h62, 7'h63, 7'h65, 7'h68, 7'h10};
  logic [15:0] code_v[6] = '{16'h0000, 16'h7fff, 16'h1234, 16'h8000, 16'h0234, 16'hbfff};
  logic [3:0]  flag_v[6] = '{4'h0, 4'h2, 4'h8, 4'h1, 4'h4, 4'h0};
  logic [15:0] exp_v[6] = '{16'h0000, 16'h7fff, 16'h7fff, 16'h8000, 16'h8000, 16'hbfff};

  always #25 i_clk_sys = ~i_clk_sys;

  adc_output_formatter DUT (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(1'b1), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_smp_valid(i_smp_valid), .o_smp_ready(o_smp_ready), .i_smp_code(i_smp_code),
    .i_smp_over_pos(smp_flags[3]), .i_smp_over_neg(smp_flags[2]), .i_smp_at_pos(smp_flags[1]),
    .i_smp_at_neg(smp_flags[0]), .i_smp_extra(i_smp_extra), .i_smp_chan(i_smp_chan),
    .i_post_processing(i_post_processing), .o_data_out(o_data_out),
    .o_extra_bits(o_extra_bits),
    .o_overrange_flag(o_overrange_flag), .o_word_marker(o_word_marker),
    .o_output_strobe_clock(o_output_strobe_clock), .o_out_enable(o_out_enable),
    .o_driver_current_select(o_driver_current_select));

  host_receiver_model rcv (
    .i_clk_sys(i_clk_sys), .i_data(o_data_out), .i_extra(o_extra_bits),
    .i_ovr(o_overrange_flag), .i_marker(o_word_marker), .i_strobe(o_output_strobe_clock));

  // Single comparison point
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    #2 i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(posedge i_clk_sys);
    #2 i_reg_wr = 1'b0;
  endtask

  // Read data is combinational, so look once the address has settled
  task automatic reg_rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    #2 i_reg_addr = a;
    #5 check("register", {8'h00, o_reg_rdata}, {8'h00, exp});
  endtask

  // Hold the sample until an edge sees ready high
  task automatic send(input logic [15:0] c, input logic [3:0] f, input logic [2:0] ch);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    #2 i_smp_code = c;
    smp_flags = f;
    i_smp_chan = ch;
    i_smp_extra = ch[1:0];
    i_smp_valid = 1'b1;
    while (o_smp_ready !== 1'b1 && n < 200) begin
      @(posedge i_clk_sys);
      #2 n++;
    end
    @(posedge i_clk_sys);
    #2 i_smp_valid = 1'b0;
    if (n == 200) check("sample ready", 16'h0000, 16'h0001);
    // Free-running strobe: drop edges that still carry earlier words
    repeat (2) @(posedge i_clk_sys);
    #2 rcv.cap_q.delete();
  endtask

  // Next captured word, optionally only rising halves
  task automatic pop(input logic rise_only, output logic [20:0] wd);
    int n;
    n = 0;
    wd = 21'h0;
    while (n < 400) begin
      if (rcv.cap_q.size() > 0) begin
        wd = rcv.cap_q.pop_front();
        if (!rise_only || wd[20]) n = 1000;
      end else begin
        @(posedge i_clk_sys);
        n++;
      end
    end
    if (n < 1000) check("captured word", 16'h0000, 16'h0001);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #(50 * 20000);
    err_total++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge i_clk_sys);
    #2 i_reset = 1'b0;
    for (int i = 0; i < 6; i++) reg_rd(adr_v[i], rst_v[i]);
    for (int i = 0; i < 6; i++) reg_wr(adr_v[i], wr_v[i]);
    for (int i = 0; i < 6; i++) reg_rd(adr_v[i], rb_v[i]);
    for (int i = 0; i < 5; i++) reg_wr(adr_v[i], rst_v[i]);
    $display("test registers done");
    // Two's complement then offset binary, with saturation
    for (int fm = 0; fm < 2; fm++) begin
      reg_wr(7'h62, fm == 0 ? 8'h03 : 8'h02);
      rcv.cap_q.delete();
      for (int i = 0; i < 6; i++) begin
        send(code_v[i], flag_v[i], 3'h0);
        pop(1'b1, w);
        check("data", w[15:0], exp_v[i] ^ (fm == 0 ? 16'h0000 : 16'h8000));
        check("overrange", w[18], flag_v[i][3] | flag_v[i][2]);
      end
    end
    $display("test format done");
    // Octal channels: marker with first channel, flag per channel;
    // randomized words are decoded by xor with bit 0
    reg_wr(7'h07, 8'h71);
    reg_wr(7'h62, 8'h03);
    rcv.cap_q.delete();
    for (int c = 0; c < 8; c++) begin
      send(16'h0100 + c, c == 3 ? 4'h8 : 4'h0, c[2:0]);
      pop(1'b1, w);
      check("marker", w[19], c == 0);
      check("overrange", w[18], c == 3);
      check("data", w[15:0] ^ {{15{w[0]}}, 1'b0}, c == 3 ? 16'h7fff : 16'h0100 + c);
      check("extra", w[17:16], c[1:0]);
    end
    for (int q = 0; q < 2; q++) begin
      reg_wr(7'h07, q == 0 ? 8'h00 : 8'h02);
      send(16'h0011, 4'h0, 3'h0);
      pop(1'b1, w);
      check("marker", w[19], q == 1);
    end
    $display("test channels done");
    // DDR halves: even first, MSB first, inverted pairs
    for (int k = 0; k < 3; k++) begin
      reg_wr(7'h65, k == 2 ? 8'hff : 8'h00);
      reg_wr(7'h62, k == 0 ? 8'h05 : 8'h0d);
      rcv.cap_q.delete();
      send(16'h7fff, 4'h8, 3'h0);
      pop(1'b1, w);
      check("rising half", w[7:0], k == 0 ? 8'hff : (k == 1 ? 8'h7f : 8'h80));
      pop(1'b0, w);
      check("falling half", w[7:0], k == 0 ? 8'h7f : (k == 1 ? 8'hff : 8'h00));
      check("overrange half", w[18], 1'b1);
    end
    reg_wr(7'h65, 8'h00);
    $display("test ddr done");
    // Serialized: first channel on the top lane, MSB with the marker
    reg_wr(7'h07, 8'h70);
    reg_wr(7'h62, 8'h07);
    for (int c = 0; c < 8; c++) send({4'(c), 12'h0a5}, c == 5 ? 4'h8 : 4'h0, c[2:0]);
    pop(1'b0, w);
    for (int n = 0; n < 20 && w[19] !== 1'b1; n++) pop(1'b0, w);
    check("serial marker", w[19], 1'b1);
    check("serial overrange", w[18], 1'b1);
    for (int b = 15; b >= 0; b--) begin
      for (int l = 0; l < 8; l++) lane_w[l][b] = w[l];
      if (b > 0) pop(1'b0, w);
    end
    for (int l = 0; l < 8; l++)
      check("serial lane", lane_w[l], l == 2 ? 16'h7fff : {4'(7 - l), 12'h0a5});
    $display("test serial done");
    // Disabled outputs hold the FIFO until it refuses
    reg_wr(7'h62, 8'h01);
    repeat (3) @(posedge i_clk_sys);
    check("enable", o_out_enable, 1'b0);
    check("strobe", o_output_strobe_clock, 1'b0);
    rcv.cap_q.delete();
    for (int i = 0; i < 8; i++) send(16'h0040 + i, 4'h0, 3'h0);
    repeat (4) @(posedge i_clk_sys);
    check("ready when full", o_smp_ready, 1'b0);
    check("words while off", rcv.cap_q.size(), 16'h0000);
    reg_wr(7'h62, 8'h03);
    // First rising edge after enable still shows the old word
    repeat (2) @(posedge i_clk_sys);
    #2 rcv.cap_q.delete();
    for (int i = 0; i < 8; i++) begin
      pop(1'b1, w);
      check("drained data", w[15:0], 16'h0040 + i);
    end
    check("ready when empty", o_smp_ready, 1'b1);
    // Post-processing delays data by four words, the flag stays direct
    @(posedge i_clk_sys);
    #2 i_post_processing = 1'b1;
    for (int i = 0; i < 4; i++) begin
      send(16'h0050 + i, i == 0 ? 4'h8 : 4'h0, 3'h0);
      pop(1'b1, w);
      check("delayed data", w[15:0], 16'h0044 + i);
      check("direct flag", w[18], i == 0);
    end
    $display("test disable done");
    end_of_test();
  end
endmodule // adc_output_formatter_test
